// *** src/clear_exec_defines.vh ***
// Constants for the clearing-instruction execute block
`ifndef CLEAR_EXEC_DEFINES_VH
`define CLEAR_EXEC_DEFINES_VH
`define OPCODE_WIDTH 14
`define CLRREG_MASK 14'h3F80
`define CLRREG_CODE 14'h0180
`define CLRWORK_MASK 14'h3F80
`define CLRWORK_CODE 14'h0100
`define CLRDOG_CODE 14'h0064
`define ADDR_WIDTH 7
`define DATA_WIDTH 8
`define DOG_WIDTH 8
`define PRE_WIDTH 8
`define ZERO_BYTE 8'h00
`define PHASE_Q1 2'h0
`define PHASE_Q2 2'h1
`define PHASE_Q3 2'h2
`define PHASE_Q4 2'h3
`define REG_STATUS 32'h00000000
`define REG_MASK 32'h00000004
`define REG_CTRL 32'h00000008
`define REG_STATE 32'h0000000C
`define REG_COUNT 32'h00000010
`define CTRL_RESET 32'h00000000
`endif

// *** src/axil_regs.v ***
// AXI4-Lite register slave for the clearing-instruction block
`timescale 1ns/1ps
`include "clear_exec_defines.vh"
module axil_regs (
	input wire clk,
	input wire rstn,
	input wire [31:0] awaddr,
	input wire awvalid,
	output reg awready,
	input wire [31:0] wdata,
	input wire [3:0] wstrb,
	input wire wvalid,
	output reg wready,
	output reg [1:0] bresp,
	output reg bvalid,
	input wire bready,
	input wire [31:0] araddr,
	input wire arvalid,
	output reg arready,
	output reg [31:0] rdata,
	output reg [1:0] rresp,
	output reg rvalid,
	input wire rready,
	input wire [2:0] events,
	input wire [31:0] stateWord,
	input wire [31:0] countWord,
	output reg [31:0] ctrl,
	output reg irq
);
	reg [31:0] wAddr;
	reg haveAddr;
	reg haveData;
	reg [31:0] wData;
	reg [2:0] status;
	reg [2:0] mask;
	reg wstrbOk;
	wire doWrite = haveAddr && haveData && !bvalid;
	wire mapped = (wAddr[31:5] == 27'h0) && (wAddr[4:2] <= 3'h4);
	wire [2:0] clearBits = (doWrite && wAddr == `REG_STATUS) ? wData[2:0] : 3'h0;
	wire [2:0] next_status = events | (status & ~clearBits);
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			awready <= 1'b0;
			wready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= 2'h0;
			haveAddr <= 1'b0;
			haveData <= 1'b0;
			wAddr <= 32'h0;
			wData <= 32'h0;
			status <= 3'h0;
			mask <= 3'h0;
			ctrl <= `CTRL_RESET;
			irq <= 1'b0;
		end else begin
			awready <= !haveAddr && !awready && awvalid;
			wready <= !haveData && !wready && wvalid;
			if (awvalid && awready) begin
				haveAddr <= 1'b1;
				wAddr <= awaddr;
			end
			if (wvalid && wready) begin
				haveData <= 1'b1;
				wData <= wdata;
			end
			// Set wins over write-one-to-clear
			status <= next_status;
			irq <= |(next_status & mask);
			if (doWrite) begin
				haveAddr <= 1'b0;
				haveData <= 1'b0;
				bvalid <= 1'b1;
				bresp <= mapped ? 2'h0 : 2'h2;
				if (wAddr == `REG_MASK && wstrbOk)
					mask <= wData[2:0];
				if (wAddr == `REG_CTRL && wstrbOk)
					ctrl <= wData;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end
	// Only the lane 0 strobe gates mask and ctrl writes, though ctrl also takes its prescale ratio from lane 1
	always @(posedge clk or negedge rstn) begin
		if (!rstn)
			wstrbOk <= 1'b0;
		else if (wvalid && wready)
			wstrbOk <= wstrb[0];
	end
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h0;
			rresp <= 2'h0;
		end else begin
			arready <= !arready && !rvalid && arvalid;
			if (arvalid && arready) begin
				rvalid <= 1'b1;
				rresp <= 2'h0;
				case (araddr)
					`REG_STATUS: rdata <= {29'h0, status};
					`REG_MASK: rdata <= {29'h0, mask};
					`REG_CTRL: rdata <= ctrl;
					`REG_STATE: rdata <= stateWord;
					`REG_COUNT: rdata <= countWord;
					default: begin
						rdata <= 32'h0;
						rresp <= 2'h2;
					end
				endcase
			end else if (rvalid && rready) begin
				rvalid <= 1'b0;
			end
		end
	end
endmodule

// *** src/clear_instruction_execute.v ***
// Execute stage for the three clearing instructions
// Contract
// - Clear-register op writes zero to addressed register and sets zero flag
// - Clear-working op zeroes working register, sets zero flag, reads no register
// - Clear-watchdog op resets watchdog counter to zero, restarting timeout
// - Clear-watchdog op zeroes prescaler count, keeping assignment and ratio
// - Clear-watchdog op sets timeout and powerdown flags to one only (a watchdogTimeout pulse in the same cycle leaves timeoutFlagN at zero here)
//
// Local design decisions: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "clear_exec_defines.vh"
module clear_instruction_execute #(
	parameter DOG_W = `DOG_WIDTH,
	parameter PRE_W = `PRE_WIDTH
) (
	input wire clk,
	input wire rstn,
	input wire [`OPCODE_WIDTH-1:0] opcode,
	input wire opValid,
	input wire [31:0] awaddr,
	input wire awvalid,
	output wire awready,
	input wire [31:0] wdata,
	input wire [3:0] wstrb,
	input wire wvalid,
	output wire wready,
	output wire [1:0] bresp,
	output wire bvalid,
	input wire bready,
	input wire [31:0] araddr,
	input wire arvalid,
	output wire arready,
	output wire [31:0] rdata,
	output wire [1:0] rresp,
	output wire rvalid,
	input wire rready,
	output reg [1:0] phase,
	output reg fileWe,
	output reg [`ADDR_WIDTH-1:0] fileAddr,
	output reg [`DATA_WIDTH-1:0] fileData,
	output reg fileRe,
	output reg [`DATA_WIDTH-1:0] working,
	output reg zeroFlag,
	output reg timeoutFlagN,
	output reg powerdownFlagN,
	output reg [DOG_W-1:0] watchdogCounter,
	output reg [PRE_W-1:0] prescaleCount,
	output reg watchdogTimeout,
	output wire irq
);
	wire [31:0] ctrl;
	reg [`OPCODE_WIDTH-1:0] held;
	reg heldValid;
	reg [2:0] events;
	wire isClrReg = (held & `CLRREG_MASK) == `CLRREG_CODE;
	wire isClrWork = (held & `CLRWORK_MASK) == `CLRWORK_CODE;
	wire isClrDog = held == `CLRDOG_CODE;
	wire atQ4 = phase == `PHASE_Q4;
	// Ctrl: bit0 watchdog enable, bits[15:8] prescale ratio (untouched by clear)
	wire dogEnable = ctrl[0];
	wire [PRE_W-1:0] ratio = ctrl[8 +: PRE_W];
	wire doClrDog = heldValid && atQ4 && isClrDog;
	// Zero-extended so narrow counts still fill a byte lane
	wire [PRE_W+15:0] preWide = {16'h0000, prescaleCount};
	wire [DOG_W+15:0] dogWide = {16'h0000, watchdogCounter};
	axil_regs regs (
		.clk(clk),
		.rstn(rstn),
		.awaddr(awaddr),
		.awvalid(awvalid),
		.awready(awready),
		.wdata(wdata),
		.wstrb(wstrb),
		.wvalid(wvalid),
		.wready(wready),
		.bresp(bresp),
		.bvalid(bvalid),
		.bready(bready),
		.araddr(araddr),
		.arvalid(arvalid),
		.arready(arready),
		.rdata(rdata),
		.rresp(rresp),
		.rvalid(rvalid),
		.rready(rready),
		.events(events),
		.stateWord({16'h0, working, 4'h0, timeoutFlagN, powerdownFlagN, zeroFlag,
			watchdogTimeout}),
		.countWord({16'h0000, preWide[7:0], dogWide[7:0]}),
		.ctrl(ctrl),
		.irq(irq)
	);
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			phase <= `PHASE_Q1;
			held <= {`OPCODE_WIDTH{1'b0}};
			heldValid <= 1'b0;
		end else begin
			phase <= phase + 2'h1;
			// Opcode latched only in Q4, held from Q1, so one word spans four cycles
			if (phase == `PHASE_Q4) begin
				held <= opcode;
				heldValid <= opValid;
			end
		end
	end
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			fileWe <= 1'b0;
			fileAddr <= {`ADDR_WIDTH{1'b0}};
			fileData <= `ZERO_BYTE;
			fileRe <= 1'b0;
			working <= `ZERO_BYTE;
			zeroFlag <= 1'b0;
			timeoutFlagN <= 1'b1;
			powerdownFlagN <= 1'b1;
			events <= 3'h0;
		end else begin
			fileWe <= 1'b0;
			events <= 3'h0;
			// Read strobe in Q2 for the register op only, none for the working op
			fileRe <= heldValid && phase == `PHASE_Q1 && isClrReg;
			fileAddr <= held[`ADDR_WIDTH-1:0];
			if (heldValid && atQ4) begin
				if (isClrReg) begin
					fileWe <= 1'b1;
					fileData <= `ZERO_BYTE;
					zeroFlag <= 1'b1;
					events[0] <= 1'b1;
				end else if (isClrWork) begin
					working <= `ZERO_BYTE;
					zeroFlag <= 1'b1;
					events[1] <= 1'b1;
				end else if (isClrDog) begin
					timeoutFlagN <= 1'b1;
					powerdownFlagN <= 1'b1;
					events[2] <= 1'b1;
				end
			end
			if (watchdogTimeout)
				timeoutFlagN <= 1'b0;
		end
	end
	// Minimal watchdog so the clear has something to act on
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			watchdogCounter <= {DOG_W{1'b0}};
			prescaleCount <= {PRE_W{1'b0}};
			watchdogTimeout <= 1'b0;
		end else begin
			watchdogTimeout <= 1'b0;
			if (doClrDog) begin
				watchdogCounter <= {DOG_W{1'b0}};
				prescaleCount <= {PRE_W{1'b0}};
			end else if (dogEnable) begin
				if (prescaleCount >= ratio) begin
					prescaleCount <= {PRE_W{1'b0}};
					watchdogCounter <= watchdogCounter + {{(DOG_W-1){1'b0}}, 1'b1};
					watchdogTimeout <= &watchdogCounter;
				end else begin
					prescaleCount <= prescaleCount + {{(PRE_W-1){1'b0}}, 1'b1};
				end
			end
		end
	end
endmodule

// *** sim/clear_exec_assertions.sv ***
// Checker for the clearing-instruction execute block
`timescale 1ns/1ps
module clear_exec_checker #(
	parameter DOG_W = 8,
	parameter PRE_W = 8
) (
	input wire clk,
	input wire rstn,
	input wire [13:0] opcode,
	input wire opValid,
	input wire [1:0] phase,
	input wire fileWe,
	input wire [6:0] fileAddr,
	input wire [7:0] fileData,
	input wire fileRe,
	input wire [7:0] working,
	input wire zeroFlag,
	input wire timeoutFlagN,
	input wire powerdownFlagN,
	input wire [DOG_W-1:0] watchdogCounter,
	input wire [PRE_W-1:0] prescaleCount
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	wire take = phase == 2'h3 && opValid;
	wire isReg = take && (opcode & 14'h3F80) == 14'h0180;
	wire isWork = take && (opcode & 14'h3F80) == 14'h0100;
	wire isDog = take && opcode == 14'h0064;
	sequence idleWe;
		!fileWe [*2];
	endsequence
	sequence regWrite;
		fileWe && zeroFlag;
	endsequence
	a_reg_clear: assert property (isReg |-> ##2 idleWe ##[1:2] regWrite)
		else $error("clear-register write missing");
	// Opcode taken five clocks before the write; a later op may already be held
	a_reg_target: assert property (fileWe |->
		fileAddr == $past(opcode[6:0], 5) && fileData == 8'h00)
		else $error("clear-register wrong target or data");
	a_w_clear: assert property (isWork |-> ##[4:5] working == 8'h00 && zeroFlag)
		else $error("working register not cleared");
	a_w_noread: assert property (isWork |-> ##1 !fileRe [*4])
		else $error("register read during clear-working");
	a_dog_zero: assert property (isDog |->
		##[4:5] watchdogCounter == 0 && prescaleCount == 0)
		else $error("watchdog counts not cleared");
	a_dog_flags: assert property (isDog |-> ##[4:5] timeoutFlagN && powerdownFlagN)
		else $error("timeout or powerdown flag not set");
	a_dog_others: assert property (isDog |-> ##5 $stable(zeroFlag) && $stable(working))
		else $error("clear-watchdog touched other state");
	a_we_pulse: assert property (fileWe |=> !fileWe)
		else $error("register write longer than one clock");
endmodule
bind clear_instruction_execute clear_exec_checker #(.DOG_W(DOG_W), .PRE_W(PRE_W)) chk (.*);

// *** sim/testbench.sv ***
// Testbench for the clearing-instruction execute block
`timescale 1ns/1ps
module testbench;
	reg clk = 1'h0, rstn = 1'h0, opValid = 1'h0, awvalid = 1'h0, wvalid = 1'h0;
	reg bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	reg [13:0] opcode = 14'h0000;
	reg [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rd;
	reg [3:0] wstrb = 4'hF;
	reg [1:0] rr, br;
	wire awready, wready, bvalid, arready, rvalid, fileWe, fileRe, zeroFlag, irq;
	wire timeoutFlagN, powerdownFlagN, watchdogTimeout;
	wire [1:0] bresp, rresp, phase;
	wire [31:0] rdata;
	wire [6:0] fileAddr;
	wire [7:0] fileData, working;
	wire [3:0] watchdogCounter, prescaleCount;
	integer n_fail = 0, check_count = 0, nWe = 0, nRe = 0, i;
	// Short counts so the watchdog wraps within a few dozen clocks
	clear_instruction_execute #(.DOG_W(4), .PRE_W(4)) uut (.*);
	initial begin
		forever #5 clk = ~clk;
	end
	always @(negedge clk) begin
		nWe = nWe + (fileWe === 1'h1);
		nRe = nRe + (fileRe === 1'h1);
	end
	task chk(input [31:0] g, input [31:0] e);
		begin
			check_count = check_count + 1;
			if (g !== e) begin
				n_fail = n_fail + 1;
				$display("BAD t=%0t got=%h exp=%h", $time, g, e);
			end
		end
	endtask
	task issue(input [13:0] op);
		begin
			while (phase !== 2'h2) @(negedge clk);
			@(posedge clk);
			opcode <= op;
			opValid <= 1'h1;
			@(posedge clk);
			opValid <= 1'h0;
			repeat (6) @(negedge clk);
		end
	endtask
	task wr(input [31:0] a, input [31:0] d);
		reg ab, wb, b;
		begin
			@(posedge clk);
			awaddr <= a;
			wdata <= d;
			awvalid <= 1'h1;
			wvalid <= 1'h1;
			bready <= 1'h1;
			b = 1'h0;
			while (!b) begin
				@(negedge clk);
				ab = awvalid && awready;
				wb = wvalid && wready;
				b = bvalid === 1'h1;
				br = bresp;
				@(posedge clk);
				if (ab) awvalid <= 1'h0;
				if (wb) wvalid <= 1'h0;
			end
			bready <= 1'h0;
		end
	endtask
	task rdr(input [31:0] a);
		reg ab, b;
		begin
			@(posedge clk);
			araddr <= a;
			arvalid <= 1'h1;
			rready <= 1'h1;
			b = 1'h0;
			while (!b) begin
				@(negedge clk);
				ab = arvalid && arready;
				b = rvalid === 1'h1;
				rd = rdata;
				rr = rresp;
				@(posedge clk);
				if (ab) arvalid <= 1'h0;
			end
			rready <= 1'h0;
		end
	endtask
	task test_clear_working_op;
		begin
			nWe = 0;
			nRe = 0;
			issue(14'h0100);
			issue(14'h017F);
			chk(working, 32'h0);
			chk(zeroFlag, 32'h1);
			chk(nRe + nWe, 32'h0);
		end
	endtask
	task test_clrreg;
		begin
			nWe = 0;
			nRe = 0;
			issue(14'h01FF);
			issue(14'h0180);
			chk(nWe, 32'h2);
			chk(nRe, 32'h2);
			chk(zeroFlag, 32'h1);
		end
	endtask
	task test_dog;
		begin
			wr(32'h8, 32'h101);
			i = 0;
			while (timeoutFlagN !== 1'h0 && i < 500) begin
				@(negedge clk);
				i = i + 1;
			end
			repeat (10) @(negedge clk);
			// Stop counting so the cleared value can be judged at leisure
			wr(32'h8, 32'h100);
			chk(timeoutFlagN, 32'h0);
			issue(14'h0064);
			chk({timeoutFlagN, powerdownFlagN, zeroFlag}, 32'h7);
			chk({watchdogCounter, prescaleCount}, 32'h0);
			rdr(32'h8);
			chk(rd, 32'h100);
		end
	endtask
	task test_irq;
		begin
			chk(irq, 32'h0);
			wr(32'h4, 32'h7);
			chk(br, 32'h0);
			repeat (3) @(negedge clk);
			chk(irq, 32'h1);
			wr(32'h0, 32'h7);
			repeat (3) @(negedge clk);
			chk(irq, 32'h0);
			rdr(32'h40);
			chk(rr, 32'h2);
			wr(32'h40, 32'h0);
			chk(br, 32'h2);
		end
	endtask
	task final_report;
		begin
			$display("checks=%0d fails=%0d", check_count, n_fail);
			if (n_fail == 0 && check_count > 0)
				$display("Testbench passed");
			else
				$display("Testbench failed");
			$finish;
		end
	endtask
	initial begin
		repeat (12) @(posedge clk);
		rstn <= 1'h1;
		test_clear_working_op;
		test_clrreg;
		test_dog;
		test_irq;
		final_report;
	end
	initial begin
		#200000;
		n_fail = n_fail + 1;
		final_report;
	end
endmodule
